// File: verilog/acs_sequencer.v
// adc conversion sequencer: module port registers and conversion control
//
// Contract
// - start bit 2 converts channel 1, result into channel 1 result
// - start bit 1 converts channel 2, result into channel 2 result
// - start bit 0 converts temperature, result into temperature result
// - cpu halted while converting; launching start bit cleared at end
// - priority channel 1, then 2, then temperature; selector 0 is differential
// - temperature alone with nonzero selector: no conversion, no result
// - nonzero selector routes chosen source to channel 1 or 2
// - selector codes 4 to 7 force fixed 0.7 gain
// - settings a: gain, clock code, resolution, coarse offset fields
// - settings b: bias field; channels also have reference select
// - adc clock is system clock divided by 4 up to 512
// - resolution code sets bit count and adc clocks per conversion
// - settings b reset to 0070h, others to 0000h
// - decodes 00h to 09h; result registers read only
// - go bit 15 starts transfer, bit 14 read; device ends it
// - only low 8 address bits decoded; address port untouched
`timescale 1ns/10ps
`include "acs_map.vh"
module acs_sequencer #(
   parameter NUM_CH = 3,
   parameter DATA_W = 16
) (
   input wire ref_clk_i,
   input wire resetn_i,
   input wire [DATA_W-1:0] module_address_port_i,
   input wire [DATA_W-1:0] module_data_port_i,
   input wire [DATA_W-1:0] module_control_port_i,
   input wire [DATA_W-1:0] conv_result_i,
   output reg [DATA_W-1:0] module_data_port_o,
   output reg module_data_load_o,
   output reg transfer_done_o,
   output reg cpu_halt_o,
   output reg conv_run_o,
   output wire conv_clk_o,
   output reg [1:0] conv_source_o,
   output reg [3:0] single_ended_select_o,
   output reg [4:0] gain_code_o,
   output reg fixed_gain_o,
   output reg [2:0] resolution_code_o,
   output reg [3:0] coarse_offset_code_o,
   output reg [2:0] bias_code_o,
   output reg [1:0] reference_select_o
);
   localparam ST_IDLE = 2'b01;
   localparam ST_CONV = 2'b10;

   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [DATA_W-1:0] ctrl_reg;
   reg [DATA_W-1:0] ctrl_next;
   reg [NUM_CH-1:0] act_reg;
   reg [NUM_CH-1:0] act_next;
   reg xfer_wait_reg;
   reg launch_w;
   reg refuse_w;
   reg [NUM_CH-1:0] pick_w;
   reg [DATA_W-1:0] pick_cfga;
   reg [DATA_W-1:0] pick_cfgb;
   reg [DATA_W-1:0] rd_mux;
   wire [7:0] addr_w;
   wire in_range;
   wire take;
   wire wr_take;
   wire rd_take;
   wire [NUM_CH-1:0] start_vec;
   wire [3:0] se_w;
   wire se_fixed;
   wire timer_done;
   wire [NUM_CH*DATA_W-1:0] cfga_all;
   wire [NUM_CH*DATA_W-1:0] cfgb_all;
   wire [NUM_CH*DATA_W-1:0] result_all;
   integer k;
   // own loop index per process keeps each variable single-driven
   integer j;

   // ----------------------------------------------------------------
   // module port transfers
   // ----------------------------------------------------------------
   // low byte decode only
   assign addr_w = module_address_port_i[7:0];
   assign in_range = (addr_w <= `ACS_ADDR_LAST);
   assign take = module_control_port_i[`ACS_GO_BIT] && !xfer_wait_reg && in_range;
   assign wr_take = take && !module_control_port_i[`ACS_READ_BIT];
   assign rd_take = take && module_control_port_i[`ACS_READ_BIT];

   // go stays high until the cpu sees done; guard against a second take
   always @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         xfer_wait_reg <= 1'b0;
      end else if (take) begin
         xfer_wait_reg <= 1'b1;
      end else if (!module_control_port_i[`ACS_GO_BIT]) begin
         xfer_wait_reg <= 1'b0;
      end
   end

   always @* begin
      rd_mux = `ACS_RST_ZERO;
      if (addr_w == `ACS_ADDR_CTRL) begin
         rd_mux = ctrl_reg;
      end
      for (k = 0; k < NUM_CH; k = k + 1) begin
         if (addr_w == k * `ACS_CH_STRIDE + `ACS_OFS_RESULT) begin
            rd_mux = result_all[k*DATA_W +: DATA_W];
         end
         if (addr_w == k * `ACS_CH_STRIDE + `ACS_OFS_CFGA) begin
            rd_mux = cfga_all[k*DATA_W +: DATA_W];
         end
         if (addr_w == k * `ACS_CH_STRIDE + `ACS_OFS_CFGB) begin
            rd_mux = cfgb_all[k*DATA_W +: DATA_W];
         end
      end
   end

   always @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         transfer_done_o <= 1'b0;
         module_data_load_o <= 1'b0;
         module_data_port_o <= `ACS_RST_ZERO;
      end else begin
         transfer_done_o <= take;
         module_data_load_o <= rd_take;
         if (rd_take) begin
            module_data_port_o <= rd_mux;
         end
      end
   end

   // ----------------------------------------------------------------
   // per channel settings and results
   // ----------------------------------------------------------------
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch = ch + 1) begin : g_ch
         reg [DATA_W-1:0] cfga_reg;
         reg [DATA_W-1:0] cfgb_reg;
         reg [DATA_W-1:0] result_reg;
         wire [7:0] base_w;
         wire [31:0] base_full;
         wire [DATA_W-1:0] mask_b;
         // product is 32 bits wide; only the low byte is an address
         assign base_full = ch * `ACS_CH_STRIDE;
         assign base_w = base_full[7:0];
         assign mask_b = (ch == NUM_CH - 1) ? `ACS_MASK_CFGB_T : `ACS_MASK_CFGB_CH;
         always @(posedge ref_clk_i) begin
            if (!resetn_i) begin
               cfga_reg <= `ACS_RST_ZERO;
               cfgb_reg <= `ACS_RST_CFGB;
               result_reg <= `ACS_RST_ZERO;
            end else begin
               if (wr_take && addr_w == base_w + `ACS_OFS_CFGA) begin
                  cfga_reg <= module_data_port_i & `ACS_MASK_CFGA;
               end
               if (wr_take && addr_w == base_w + `ACS_OFS_CFGB) begin
                  cfgb_reg <= module_data_port_i & mask_b;
               end
               if (timer_done && act_reg[ch]) begin
                  result_reg <= conv_result_i;
               end
            end
         end
         assign cfga_all[ch*DATA_W +: DATA_W] = cfga_reg;
         assign cfgb_all[ch*DATA_W +: DATA_W] = cfgb_reg;
         assign result_all[ch*DATA_W +: DATA_W] = result_reg;
      end
   endgenerate

   // ----------------------------------------------------------------
   // launch selection
   // ----------------------------------------------------------------
   // bit order of start_vec follows channel index: ch1, ch2, temp
   assign start_vec = {ctrl_reg[`ACS_START_TEMP_BIT],
                       ctrl_reg[`ACS_START_CH2_BIT],
                       ctrl_reg[`ACS_START_CH1_BIT]};
   assign se_w = ctrl_reg[`ACS_SE_MSB:`ACS_SE_LSB];
   assign se_fixed = (se_w >= `ACS_SE_FIXED_FIRST) && (se_w <= `ACS_SE_FIXED_LAST);

   always @* begin
      pick_w = {NUM_CH{1'b0}};
      launch_w = 1'b0;
      refuse_w = 1'b0;
      if (state_reg == ST_IDLE) begin
         if (start_vec[0]) begin
            pick_w[0] = 1'b1;
            launch_w = 1'b1;
         end else if (start_vec[1]) begin
            pick_w[1] = 1'b1;
            launch_w = 1'b1;
         end else if (start_vec[2]) begin
            if (se_w == `ACS_SE_NONE) begin
               pick_w[2] = 1'b1;
               launch_w = 1'b1;
            end else begin
               refuse_w = 1'b1;
            end
         end
      end
   end

   always @* begin
      pick_cfga = `ACS_RST_ZERO;
      pick_cfgb = `ACS_RST_ZERO;
      for (j = 0; j < NUM_CH; j = j + 1) begin
         if (pick_w[j]) begin
            pick_cfga = cfga_all[j*DATA_W +: DATA_W];
            pick_cfgb = cfgb_all[j*DATA_W +: DATA_W];
         end
      end
   end

   // ----------------------------------------------------------------
   // control register and state machine
   // ----------------------------------------------------------------
   always @* begin
      ctrl_next = ctrl_reg;
      state_next = state_reg;
      act_next = act_reg;
      case (state_reg)
         ST_IDLE: begin
            if (launch_w) begin
               state_next = ST_CONV;
               act_next = pick_w;
            end
            // refused temperature request drops without a result
            if (refuse_w) begin
               ctrl_next[`ACS_START_TEMP_BIT] = 1'b0;
            end
         end
         ST_CONV: begin
            if (timer_done) begin
               state_next = ST_IDLE;
               act_next = {NUM_CH{1'b0}};
               if (act_reg[0]) begin
                  ctrl_next[`ACS_START_CH1_BIT] = 1'b0;
               end
               if (act_reg[1]) begin
                  ctrl_next[`ACS_START_CH2_BIT] = 1'b0;
               end
               if (act_reg[2]) begin
                  ctrl_next[`ACS_START_TEMP_BIT] = 1'b0;
               end
            end
         end
         default: begin
            state_next = ST_IDLE;
            act_next = {NUM_CH{1'b0}};
         end
      endcase
      // a software write lands after the hardware clear, so a new set wins
      if (wr_take && addr_w == `ACS_ADDR_CTRL) begin
         ctrl_next = module_data_port_i & `ACS_MASK_CTRL;
      end
   end

   always @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         state_reg <= ST_IDLE;
         ctrl_reg <= `ACS_RST_ZERO;
         act_reg <= {NUM_CH{1'b0}};
      end else begin
         state_reg <= state_next;
         ctrl_reg <= ctrl_next;
         act_reg <= act_next;
      end
   end

   // ----------------------------------------------------------------
   // converter settings and cpu halt
   // ----------------------------------------------------------------
   always @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         cpu_halt_o <= 1'b0;
         conv_run_o <= 1'b0;
         conv_source_o <= `ACS_SRC_NONE;
         single_ended_select_o <= `ACS_SE_NONE;
         gain_code_o <= 5'h00;
         fixed_gain_o <= 1'b0;
         resolution_code_o <= 3'h0;
         coarse_offset_code_o <= 4'h0;
         bias_code_o <= 3'h0;
         reference_select_o <= 2'h0;
      end else if (launch_w) begin
         cpu_halt_o <= 1'b1;
         conv_run_o <= 1'b1;
         conv_source_o <= pick_w[0] ? `ACS_SRC_CH1 :
                          pick_w[1] ? `ACS_SRC_CH2 : `ACS_SRC_TEMP;
         single_ended_select_o <= se_w;
         gain_code_o <= pick_cfga[`ACS_GAIN_MSB:`ACS_GAIN_LSB];
         fixed_gain_o <= se_fixed && !pick_w[2];
         resolution_code_o <= pick_cfga[`ACS_RES_MSB:`ACS_RES_LSB];
         coarse_offset_code_o <= pick_cfga[`ACS_CO_MSB:`ACS_CO_LSB];
         bias_code_o <= pick_cfgb[`ACS_BIAS_MSB:`ACS_BIAS_LSB];
         reference_select_o <= pick_cfgb[`ACS_REF_MSB:`ACS_REF_LSB];
      end else if (timer_done) begin
         cpu_halt_o <= 1'b0;
         conv_run_o <= 1'b0;
         conv_source_o <= `ACS_SRC_NONE;
      end
   end

   // ----------------------------------------------------------------
   // conversion timer
   // ----------------------------------------------------------------
   // divided conversion clock
   acs_conv_timer u_timer (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .start_i(launch_w),
      .clock_code_i(pick_cfga[`ACS_CLK_MSB:`ACS_CLK_LSB]),
      .resolution_code_i(pick_cfga[`ACS_RES_MSB:`ACS_RES_LSB]),
      .adc_clk_o(conv_clk_o),
      .done_o(timer_done)
   );
endmodule // acs_sequencer

// File: verilog/acs_map.vh
// register map, field positions and constants of the adc sequencer
`ifndef ACS_MAP_VH
`define ACS_MAP_VH
`define ACS_ADDR_CTRL 8'h00
`define ACS_ADDR_LAST 8'h09
`define ACS_CH_STRIDE 8'h03
`define ACS_OFS_RESULT 8'h01
`define ACS_OFS_CFGA 8'h02
`define ACS_OFS_CFGB 8'h03
`define ACS_GO_BIT 15
`define ACS_READ_BIT 14
`define ACS_START_CH1_BIT 2
`define ACS_START_CH2_BIT 1
`define ACS_START_TEMP_BIT 0
`define ACS_SE_MSB 11
`define ACS_SE_LSB 8
`define ACS_GAIN_MSB 15
`define ACS_GAIN_LSB 11
`define ACS_CLK_MSB 10
`define ACS_CLK_LSB 8
`define ACS_RES_MSB 6
`define ACS_RES_LSB 4
`define ACS_CO_MSB 3
`define ACS_CO_LSB 0
`define ACS_BIAS_MSB 6
`define ACS_BIAS_LSB 4
`define ACS_REF_MSB 1
`define ACS_REF_LSB 0
`define ACS_RST_ZERO 16'h0000
`define ACS_RST_CFGB 16'h0070
`define ACS_MASK_CTRL 16'h0F07
`define ACS_MASK_CFGA 16'hFF7F
`define ACS_MASK_CFGB_CH 16'h0073
`define ACS_MASK_CFGB_T 16'h0070
`define ACS_SE_NONE 4'h0
`define ACS_SE_FIXED_FIRST 4'h4
`define ACS_SE_FIXED_LAST 4'h7
`define ACS_SRC_NONE 2'h0
`define ACS_SRC_CH1 2'h1
`define ACS_SRC_CH2 2'h2
`define ACS_SRC_TEMP 2'h3
`define ACS_DIV_MIN 10'h004
`define ACS_LEN_RES0 12'h100
`define ACS_LEN_RES1 12'h140
`define ACS_LEN_RES2 12'h200
`define ACS_LEN_RES3 12'h280
`define ACS_LEN_RES4 12'h320
`define ACS_LEN_RES5 12'h500
`define ACS_LEN_RES6 12'h800
`endif

// File: verilog/acs_conv_timer.v
// conversion timer: adc clock divider and adc clock counter
`timescale 1ns/10ps
`include "acs_map.vh"
module acs_conv_timer (
   input wire ref_clk_i,
   input wire resetn_i,
   input wire start_i,
   input wire [2:0] clock_code_i,
   input wire [2:0] resolution_code_i,
   output reg adc_clk_o,
   output reg done_o
);
   reg run_reg;
   reg [9:0] div_cnt_reg;
   reg [9:0] div_last_reg;
   reg [9:0] half_reg;
   reg [11:0] clk_cnt_reg;
   reg [11:0] len_last_reg;
   reg [11:0] len_w;
   wire [9:0] div_w;
   wire [9:0] div_cnt_inc;

   assign div_w = `ACS_DIV_MIN << clock_code_i;
   assign div_cnt_inc = div_cnt_reg + 10'h001;

   always @* begin
      case (resolution_code_i)
         3'h0: len_w = `ACS_LEN_RES0;
         3'h1: len_w = `ACS_LEN_RES1;
         3'h2: len_w = `ACS_LEN_RES2;
         3'h3: len_w = `ACS_LEN_RES3;
         3'h4: len_w = `ACS_LEN_RES4;
         3'h5: len_w = `ACS_LEN_RES5;
         default: len_w = `ACS_LEN_RES6;
      endcase
   end

   always @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         run_reg <= 1'b0;
         div_cnt_reg <= 10'h000;
         div_last_reg <= 10'h000;
         half_reg <= 10'h000;
         clk_cnt_reg <= 12'h000;
         len_last_reg <= 12'h000;
         adc_clk_o <= 1'b0;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (start_i && !run_reg) begin
            run_reg <= 1'b1;
            div_cnt_reg <= 10'h000;
            clk_cnt_reg <= 12'h000;
            div_last_reg <= div_w - 10'h001;
            half_reg <= div_w >> 1;
            len_last_reg <= len_w - 12'h001;
            adc_clk_o <= 1'b1;
         end else if (run_reg) begin
            if (div_cnt_reg == div_last_reg) begin
               div_cnt_reg <= 10'h000;
               if (clk_cnt_reg == len_last_reg) begin
                  run_reg <= 1'b0;
                  done_o <= 1'b1;
                  adc_clk_o <= 1'b0;
               end else begin
                  clk_cnt_reg <= clk_cnt_reg + 12'h001;
                  adc_clk_o <= 1'b1;
               end
            end else begin
               div_cnt_reg <= div_cnt_inc;
               adc_clk_o <= (div_cnt_inc < half_reg);
            end
         end
      end
   end
endmodule // acs_conv_timer

// File: dv/acs_sequencer_props.sv
// port assertions for the adc conversion sequencer
`timescale 1ns/10ps
module acs_sequencer_props #(
   parameter NUM_CH = 3,
   parameter DATA_W = 16
) (
   input wire ref_clk_i,
   input wire resetn_i,
   input wire [DATA_W-1:0] module_address_port_i,
   input wire [DATA_W-1:0] module_control_port_i,
   input wire module_data_load_o,
   input wire transfer_done_o,
   input wire cpu_halt_o,
   input wire conv_run_o,
   input wire conv_clk_o,
   input wire [1:0] conv_source_o,
   input wire [3:0] single_ended_select_o,
   input wire fixed_gain_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);
   // shortest conversion is 4 x 256 system clocks
   reg [19:0] halt_cnt;
   always @(posedge ref_clk_i) begin
      if (!resetn_i || !cpu_halt_o) begin
         halt_cnt <= 20'h00000;
      end else begin
         halt_cnt <= halt_cnt + 20'h00001;
      end
   end
   take_answer_a: assert property (
      ($rose(module_control_port_i[15]) && module_address_port_i[7:0] <= 8'h09)
      |=> transfer_done_o) else $error("mapped transfer not answered");
   foreign_quiet_a: assert property (
      ($rose(module_control_port_i[15]) && module_address_port_i[7:0] > 8'h09)
      |=> !transfer_done_o) else $error("foreign address answered");
   read_load_a: assert property (
      transfer_done_o |-> module_data_load_o == $past(module_control_port_i[14]))
      else $error("data load does not match direction");
   done_pulse_a: assert property (transfer_done_o |=> !transfer_done_o)
      else $error("done longer than one cycle");
   halt_run_a: assert property (cpu_halt_o == conv_run_o)
      else $error("halt and run disagree");
   halt_length_a: assert property ($fell(cpu_halt_o) |-> halt_cnt >= 20'h003FF)
      else $error("conversion too short");
   source_busy_a: assert property (conv_run_o |-> conv_source_o != 2'h0)
      else $error("running without source");
   source_clear_a: assert property ($fell(conv_run_o) |-> conv_source_o == 2'h0)
      else $error("source kept after end");
   fixed_gain_a: assert property (conv_run_o |-> fixed_gain_o ==
      (conv_source_o != 2'h3 && single_ended_select_o >= 4'h4 && single_ended_select_o <= 4'h7))
      else $error("fixed gain wrong");
   idle_clock_a: assert property ((!conv_run_o && !$past(conv_run_o)) |-> !conv_clk_o)
      else $error("adc clock runs while idle");
   cover property (module_data_load_o);
   cover property ($fell(cpu_halt_o));
   cover property (conv_run_o && fixed_gain_o);
endmodule // acs_sequencer_props
bind acs_sequencer acs_sequencer_props #(.NUM_CH(NUM_CH), .DATA_W(DATA_W)) i_acs_sequencer_props (
   .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .module_address_port_i(module_address_port_i),
   .module_control_port_i(module_control_port_i), .module_data_load_o(module_data_load_o),
   .transfer_done_o(transfer_done_o), .cpu_halt_o(cpu_halt_o), .conv_run_o(conv_run_o),
   .conv_clk_o(conv_clk_o), .conv_source_o(conv_source_o),
   .single_ended_select_o(single_ended_select_o), .fixed_gain_o(fixed_gain_o));

// File: dv/acs_cpu_port_model.sv
// cpu side of the module port: data, address and control ports
`timescale 1ns/10ps
module acs_cpu_port_model (
   input wire ref_clk_i,
   input wire resetn_i,
   input wire req_i,
   input wire rd_i,
   input wire [15:0] addr_i,
   input wire [15:0] wdata_i,
   input wire transfer_done_i,
   input wire module_data_load_i,
   input wire [15:0] module_data_port_i,
   output reg [15:0] data_port_o,
   output reg [15:0] address_port_o,
   output reg [15:0] control_port_o
);
   reg held;
   always @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         data_port_o <= 16'h0000;
         address_port_o <= 16'h0000;
         control_port_o <= 16'h0000;
         held <= 1'b0;
      end else begin
         if (control_port_o[15] && (transfer_done_i || !req_i)) begin
            control_port_o[15] <= 1'b0;
         end
         if (module_data_load_i) begin
            data_port_o <= module_data_port_i;
         end
         if (!req_i) begin
            held <= 1'b0;
         end else if (!held && !control_port_o[15]) begin
            held <= 1'b1;
            address_port_o <= addr_i;
            control_port_o <= {1'b1, rd_i, 14'h0000};
            if (!rd_i) begin
               data_port_o <= wdata_i;
            end
         end
      end
   end
endmodule // acs_cpu_port_model

// File: dv/test_adc_conversion_sequencer.sv
// self-checking bench for the adc conversion sequencer
`timescale 1ns/10ps
module test_adc_conversion_sequencer;
   reg ref_clk = 1'b0;
   reg resetn = 1'b0;
   reg req = 1'b0;
   reg rd = 1'b0;
   reg [15:0] addr = 16'h0000;
   reg [15:0] wdata = 16'h0000;
   reg [15:0] conv_result = 16'h0000;
   reg [15:0] q;
   reg [3:0] sl;
   reg [47:0] rows [0:10];
   wire [15:0] pd, pe, pf, rdata;
   wire load, done, halt, run, cclk, fx;
   wire [1:0] src, refs;
   wire [3:0] sel, co;
   wire [4:0] gain;
   wire [2:0] res, bias;
   integer n_fail = 0;
   integer check_count = 0;
   integer i, got;
   acs_sequencer #(.NUM_CH(3), .DATA_W(16)) i_acs_sequencer (.ref_clk_i(ref_clk),
      .resetn_i(resetn), .module_address_port_i(pe), .module_data_port_i(pd),
      .module_control_port_i(pf), .conv_result_i(conv_result), .module_data_port_o(rdata),
      .module_data_load_o(load), .transfer_done_o(done), .cpu_halt_o(halt), .conv_run_o(run),
      .conv_clk_o(cclk), .conv_source_o(src), .single_ended_select_o(sel), .gain_code_o(gain),
      .fixed_gain_o(fx), .resolution_code_o(res), .coarse_offset_code_o(co),
      .bias_code_o(bias), .reference_select_o(refs));
   acs_cpu_port_model i_acs_cpu_port_model (.ref_clk_i(ref_clk), .resetn_i(resetn),
      .req_i(req), .rd_i(rd), .addr_i(addr), .wdata_i(wdata), .transfer_done_i(done),
      .module_data_load_i(load), .module_data_port_i(rdata), .data_port_o(pd),
      .address_port_o(pe), .control_port_o(pf));
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   task tally_and_finish;
      begin
         $display("checks %0d mismatches %0d", check_count, n_fail);
         if (n_fail == 0 && check_count > 0) begin
            $display("== PASSED ==");
         end else begin
            $display("== FAILED ==");
         end
         $finish;
      end
   endtask
   task chk(input [31:0] g, input [31:0] e);
      begin
         check_count = check_count + 1;
         if (g !== e) begin
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
            n_fail = n_fail + 1;
         end
      end
   endtask
   function integer adc_clocks(input [2:0] r);
      begin
         case (r)
            3'h0: adc_clocks = 256;
            3'h1: adc_clocks = 320;
            3'h2: adc_clocks = 512;
            3'h3: adc_clocks = 640;
            3'h4: adc_clocks = 800;
            3'h5: adc_clocks = 1280;
            default: adc_clocks = 2048;
         endcase
      end
   endfunction
   // ---
   // module port transfers
   // ---
   task xfer(input [15:0] a, input r, input [15:0] d, output integer ok, output [15:0] v);
      integer k;
      begin
         @(posedge ref_clk);
         addr <= a;
         rd <= r;
         wdata <= d;
         req <= 1'b1;
         ok = 0;
         for (k = 0; k < 8 && ok == 0; k = k + 1) begin
            @(negedge ref_clk);
            if (done === 1'b1) ok = 1;
         end
         @(posedge ref_clk);
         req <= 1'b0;
         @(negedge ref_clk);
         v = pd;
      end
   endtask
   task wr(input [15:0] a, input [15:0] d);
      begin
         xfer(a, 1'b0, d, got, q);
         chk(got, 1);
      end
   endtask
   task rdchk(input [15:0] a, input [15:0] e);
      begin
         xfer(a, 1'b1, 16'h0000, got, q);
         chk(got, 1);
         chk(q, e);
      end
   endtask
   // waits out one conversion; a halt that never rises ends the run, a stuck one fails the length check
   task conv(input [1:0] s, input [3:0] e, input [15:0] ca, input [15:0] cb, input [15:0] v);
      integer k, n, len;
      reg fxe;
      begin
         k = 0;
         while (halt !== 1'b1 && k < 20) begin
            @(negedge ref_clk);
            k = k + 1;
         end
         if (k >= 20) begin
            n_fail = n_fail + 1;
            tally_and_finish;
         end
         fxe = (s != 2'h3) && (e >= 4'h4) && (e <= 4'h7);
         chk({src, sel, gain, fx, res, co, bias, refs}, {s, e, ca[15:11], fxe, ca[6:4], ca[3:0],
            cb[6:4], cb[1:0]});
         @(posedge ref_clk);
         conv_result <= v;
         len = (4 << ca[10:8]) * adc_clocks(ca[6:4]);
         n = 1;
         while (halt === 1'b1 && n < 20000) begin
            @(negedge ref_clk);
            n = n + 1;
         end
         chk((n >= len) && (n <= len + 2), 1);
      end
   endtask
   initial begin
      rows[0] = {16'h0000, 16'hF8F8, 16'h0800};
      rows[1] = {16'h0001, 16'hFFFF, 16'h0000};
      rows[2] = {16'hA502, 16'hF80F, 16'hF80F};
      rows[3] = {16'h0003, 16'hFFFF, 16'h0073};
      rows[4] = {16'h0004, 16'hFFFF, 16'h0000};
      rows[5] = {16'h0005, 16'h12B4, 16'h1234};
      rows[6] = {16'h0006, 16'hFFFC, 16'h0070};
      rows[7] = {16'hFF07, 16'hFFFF, 16'h0000};
      rows[8] = {16'h0008, 16'hAAAA, 16'hAA2A};
      rows[9] = {16'h0009, 16'hFFFF, 16'h0070};
      // bias 7 suits every clock code; ch1 uses bandgap reference
      rows[10] = {16'h0003, 16'h0072, 16'h0072};
      repeat (16) @(posedge ref_clk);
      resetn <= 1'b1;
      for (i = 0; i < 11; i = i + 1) begin
         wr(rows[i][47:32], rows[i][31:16]);
         rdchk(rows[i][47:32], rows[i][15:0]);
      end
      // ---
      // conversions and corner cases
      // ---
      for (i = 0; i < 5; i = i + 1) begin
         sl = 20'h03478 >> (16 - 4 * i);
         wr({4'h0, sl, 8'h04}, 16'h0000);
         wr(16'h0000, {4'h0, sl, 8'h04});
         conv(2'h1, sl, 16'hF80F, 16'h0072, {sl, 12'h5A5});
         rdchk(16'h0000, {4'h0, sl, 8'h00});
         rdchk(16'h0001, {sl, 12'h5A5});
      end
      wr(16'h0000, 16'h0007);
      conv(2'h1, 4'h0, 16'hF80F, 16'h0072, 16'h1111);
      conv(2'h2, 4'h0, 16'h1234, 16'h0070, 16'h2222);
      conv(2'h3, 4'h0, 16'hAA2A, 16'h0070, 16'h3333);
      rdchk(16'h0000, 16'h0000);
      rdchk(16'h0001, 16'h1111);
      rdchk(16'h0004, 16'h2222);
      rdchk(16'h0007, 16'h3333);
      wr(16'h0000, 16'h0602);
      conv(2'h2, 4'h6, 16'h1234, 16'h0070, 16'h4444);
      rdchk(16'h0004, 16'h4444);
      wr(16'h0000, 16'h0101);
      got = 0;
      repeat (20) begin
         @(negedge ref_clk);
         if (halt !== 1'b0) got = 1;
      end
      chk(got, 0);
      rdchk(16'h0000, 16'h0100);
      rdchk(16'h0007, 16'h3333);
      xfer(16'h000A, 1'b0, 16'hFFFF, got, q);
      chk(got, 0);
      wr(16'h0000, 16'h0004);
      repeat (50) @(posedge ref_clk);
      resetn <= 1'b0;
      repeat (16) @(posedge ref_clk);
      resetn <= 1'b1;
      @(negedge ref_clk);
      chk({halt, run, src}, 0);
      for (i = 0; i < 10; i = i + 1) begin
         rdchk(i[15:0], (i % 3 == 0 && i > 0) ? 16'h0070 : 16'h0000);
      end
      tally_and_finish;
   end
endmodule // test_adc_conversion_sequencer
